// File: verilog/vps_pkg.sv
// Constants shared by the video parallel-to-serial shifter and its queue.
// Assumes a 32-bit Avalon-MM register port addressed in bytes.
package vps_pkg;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int TAP_IDX = 7;
    // Input arrangement codes; the unused code behaves as queue mode
    localparam logic [1:0] CFG_FIFO = 2'h0;
    localparam logic [1:0] CFG_LATCH = 2'h1;
    localparam logic [1:0] CFG_FLOP = 2'h2;
    // Register byte addresses
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_SHIFT = 4'h8;
    localparam logic [3:0] ADDR_HOLD = 4'hc;
    // Control register fields
    localparam int CTRL_W = 7;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam int CF_CFG0 = 0;
    localparam int CF_CFG1 = 1;
    localparam int CF_FREEZE = 2;
    localparam int CF_LEVEL = 3;
    localparam int CF_INHIBIT = 4;
    localparam int CF_LDINH = 5;
    localparam int CF_RECIRC = 6;
    // Status register fields
    localparam int SF_CNT = 0;
    localparam int SF_FULL = 4;
    localparam int SF_EMPTY = 5;
    localparam int SF_LAST = 6;
    localparam int SF_TAP = 7;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    typedef enum logic {BUS_IDLE, BUS_ACK} vps_bus_t;
endpackage : vps_pkg

// File: verilog/vps_fifo.sv
// Word queue that sits between the input stage and the shift register.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
module vps_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 4,
    localparam int CNT_W = $clog2(DEPTH + 1),
    localparam int PTR_W = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [W-1:0] wdata,
    input wire logic pop,
    output logic [W-1:0] rdata,
    output logic full,
    output logic empty,
    output logic [CNT_W-1:0] count
);
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic do_push, do_pop;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        if (p == PTR_W'(DEPTH - 1))
        begin
            return '0;
        end
        return p + 1'b1;
    endfunction : ptr_inc

    assign full = (cnt_q == CNT_W'(DEPTH));
    assign empty = (cnt_q == '0);
    assign count = cnt_q;
    assign rdata = mem_q[rd_q];

    always_comb
    begin
        // A pop frees the slot, so a push beside it fits even when full
        do_pop = pop && !empty;
        do_push = push && (!full || do_pop);
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (do_push)
        begin
            mem_d[wr_q] = wdata;
            wr_d = ptr_inc(wr_q);
        end
        if (do_pop)
        begin
            rd_d = ptr_inc(rd_q);
        end
        if (do_push && !do_pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (do_pop && !do_push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        mem_q <= mem_d;
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : vps_fifo

// File: verilog/vps_shifter.sv
// Video parallel-to-serial shifter with a four-word input queue.
// Assumes pins arrive unsynchronised; pixel and write clocks are sampled
// by mclk, so each must stay high and low for at least three mclk cycles.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module vps_shifter #(
    parameter int WORD_W = vps_pkg::WORD_W,
    parameter int DEPTH = vps_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [vps_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [WORD_W-1:0] data_in,
    input wire logic fifo_write_clock,
    input wire logic pixel_clk,
    input wire logic parallel_load,
    input wire logic serial_in,
    output logic serial_out_last,
    output logic serial_out_tap8
);
    localparam int SYNC_W = WORD_W + 4;
    localparam int IX_WCLK = WORD_W;
    localparam int IX_PCLK = WORD_W + 1;
    localparam int IX_PL = WORD_W + 2;
    localparam int IX_SI = WORD_W + 3;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [SYNC_W-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic wprev_q, wprev_d, pprev_q, pprev_d;
    logic [WORD_W-1:0] hold_q, hold_d;
    logic [WORD_W-1:0] sr_q, sr_d;
    logic last_q, last_d, tap_q, tap_d;
    logic [vps_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
    vps_pkg::vps_bus_t bus_q, bus_d;
    logic [31:0] rdata_q, rdata_d, rd_val;
    logic wait_q, wait_d;

    logic [WORD_W-1:0] data_s, head, push_data, ld_src;
    logic wr_edge, pix_edge, pl_s, si_s, wclk_s;
    logic [1:0] cfg;
    logic fifo_mode, freeze, lvl, shift_inh, ld_inh, recirc;
    logic src_ok, ld_go, pop, push, recirc_push;
    logic full, empty;
    logic [CNT_W-1:0] cnt;

    // Pin synchronisers and edge finders
    always_comb
    begin
        sync1_d = {serial_in, parallel_load, pixel_clk, fifo_write_clock, data_in};
        sync2_d = sync1_q;
        wprev_d = sync2_q[IX_WCLK];
        pprev_d = sync2_q[IX_PCLK];
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            wprev_q <= 1'b0;
            pprev_q <= 1'b0;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            wprev_q <= wprev_d;
            pprev_q <= pprev_d;
        end
    end

    // Data and write clock pass the same two stages, so they stay aligned
    assign data_s = sync2_q[WORD_W-1:0];
    assign wclk_s = sync2_q[IX_WCLK];
    assign wr_edge = wclk_s && !wprev_q;
    assign pix_edge = sync2_q[IX_PCLK] && !pprev_q;
    assign pl_s = sync2_q[IX_PL];
    assign si_s = sync2_q[IX_SI];

    assign cfg = {ctrl_q[vps_pkg::CF_CFG1], ctrl_q[vps_pkg::CF_CFG0]};
    assign fifo_mode = (cfg != vps_pkg::CFG_LATCH) && (cfg != vps_pkg::CFG_FLOP);
    assign freeze = ctrl_q[vps_pkg::CF_FREEZE];
    assign lvl = ctrl_q[vps_pkg::CF_LEVEL];
    assign shift_inh = ctrl_q[vps_pkg::CF_INHIBIT];
    assign ld_inh = ctrl_q[vps_pkg::CF_LDINH];
    assign recirc = ctrl_q[vps_pkg::CF_RECIRC];

    // Bypass holding register: latch follows data while the write clock is high
    always_comb
    begin
        hold_d = hold_q;
        if (cfg == vps_pkg::CFG_LATCH && wclk_s)
        begin
            hold_d = data_s;
        end
        else if (cfg == vps_pkg::CFG_FLOP && wr_edge)
        begin
            hold_d = data_s;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            hold_q <= '0;
        end
        else
        begin
            hold_q <= hold_d;
        end
    end

    // Queue feeding; a recirculated word takes priority over a pin write
    always_comb
    begin
        ld_src = fifo_mode ? head : hold_q;
        src_ok = fifo_mode ? !empty : 1'b1;
        ld_go = pix_edge && pl_s && !ld_inh && src_ok;
        pop = ld_go && fifo_mode;
        recirc_push = pop && recirc;
        push = recirc_push || (wr_edge && fifo_mode);
        push_data = recirc_push ? head : data_s;
    end

    vps_fifo #(
        .W(WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst(srst),
        .push(push),
        .wdata(push_data),
        .pop(pop),
        .rdata(head),
        .full(full),
        .empty(empty),
        .count(cnt)
    );

    // Shift register: bit 0 is stage one, bit WORD_W-1 is stage sixteen
    always_comb
    begin
        sr_d = sr_q;
        last_d = last_q;
        tap_d = tap_q;
        if (pix_edge)
        begin
            if (ld_go)
            begin
                sr_d = ld_src;
            end
            else if (!shift_inh)
            begin
                sr_d = {sr_q[WORD_W-2:0], si_s};
            end
            if (freeze)
            begin
                last_d = lvl;
            end
            else
            begin
                last_d = sr_d[WORD_W-1];
                tap_d = sr_d[vps_pkg::TAP_IDX];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sr_q <= '0;
            last_q <= 1'b0;
            tap_q <= 1'b0;
        end
        else
        begin
            sr_q <= sr_d;
            last_q <= last_d;
            tap_q <= tap_d;
        end
    end

    assign serial_out_last = last_q;
    assign serial_out_tap8 = tap_q;

    // Register read mux; unmapped addresses read zero
    always_comb
    begin
        rd_val = vps_pkg::RD_ZERO;
        if (avs_address == vps_pkg::ADDR_CTRL)
        begin
            rd_val = 32'(ctrl_q);
        end
        else if (avs_address == vps_pkg::ADDR_STATUS)
        begin
            rd_val[vps_pkg::SF_CNT +: CNT_W] = cnt;
            rd_val[vps_pkg::SF_FULL] = full;
            rd_val[vps_pkg::SF_EMPTY] = empty;
            rd_val[vps_pkg::SF_LAST] = last_q;
            rd_val[vps_pkg::SF_TAP] = tap_q;
        end
        else if (avs_address == vps_pkg::ADDR_SHIFT)
        begin
            rd_val = 32'(sr_q);
        end
        else if (avs_address == vps_pkg::ADDR_HOLD)
        begin
            rd_val = 32'(hold_q);
        end
    end

    // Every access costs one wait cycle, keeping read data registered
    always_comb
    begin
        bus_d = bus_q;
        wait_d = 1'b1;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        case (bus_q)
            vps_pkg::BUS_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    bus_d = vps_pkg::BUS_ACK;
                    wait_d = 1'b0;
                    rdata_d = avs_read ? rd_val : vps_pkg::RD_ZERO;
                end
            end
            vps_pkg::BUS_ACK:
            begin
                bus_d = vps_pkg::BUS_IDLE;
                if (avs_write && avs_address == vps_pkg::ADDR_CTRL && avs_byteenable[0])
                begin
                    ctrl_d = avs_writedata[vps_pkg::CTRL_W-1:0];
                end
            end
            default:
            begin
                bus_d = vps_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            bus_q <= vps_pkg::BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= '0;
            ctrl_q <= vps_pkg::CTRL_RST;
        end
        else
        begin
            bus_q <= bus_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    property p_bus_ack;
        (avs_read || avs_write) && bus_q == vps_pkg::BUS_IDLE |=> s_ack;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("bus answer not one cycle");

    sequence s_plain_shift;
        pix_edge && !ld_go && !shift_inh;
    endsequence

    property p_shift;
        s_plain_shift |=> sr_q == {$past(sr_q[WORD_W-2:0]), $past(si_s)};
    endproperty
    a_shift: assert property (p_shift)
        else $error("shift step wrong");

    property p_inhibit;
        pix_edge && shift_inh && !ld_go |=> $stable(sr_q);
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("register moved under inhibit");

    property p_freeze;
        pix_edge && freeze |=> serial_out_last == $past(lvl) && $stable(serial_out_tap8);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("frozen outputs changed");

    property p_tap_inner;
        s_plain_shift and freeze |=> sr_q[vps_pkg::TAP_IDX + 1] == $past(sr_q[vps_pkg::TAP_IDX]);
    endproperty
    a_tap_inner: assert property (p_tap_inner)
        else $error("stage eight stopped feeding");

    property p_ld_inh;
        pix_edge && pl_s && ld_inh && !shift_inh |=> sr_q == {$past(sr_q[WORD_W-2:0]), $past(si_s)};
    endproperty
    a_ld_inh: assert property (p_ld_inh)
        else $error("load taken while inhibited");

    property p_load_head;
        ld_go && fifo_mode |=> sr_q == $past(head);
    endproperty
    a_load_head: assert property (p_load_head)
        else $error("load did not take oldest word");

    property p_pop_only_load;
        !pop |=> cnt >= $past(cnt);
    endproperty
    a_pop_only_load: assert property (p_pop_only_load)
        else $error("queue shrank without a load");

    property p_full_drop;
        full && !pop |=> cnt == $past(cnt);
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("full queue accepted a write");

    property p_write;
        wr_edge && fifo_mode && !full && !pop |=> cnt == CNT_W'($past(cnt) + 1'b1);
    endproperty
    a_write: assert property (p_write)
        else $error("write not queued");

    property p_recirc;
        recirc_push |=> cnt == $past(cnt);
    endproperty
    a_recirc: assert property (p_recirc)
        else $error("recirculation changed occupancy");

    property p_latch;
        cfg == vps_pkg::CFG_LATCH && wclk_s |=> hold_q == $past(data_s);
    endproperty
    a_latch: assert property (p_latch)
        else $error("latch not transparent");
endmodule : vps_shifter

// File: sim/vps_far_model.sv
// Far-side model: video memory word source, pixel timing and DAC capture.
// Assumes a free-running mclk; every pin changes just after a rising mclk edge.
`timescale 1ns/1ps
module vps_far_model (
    input wire logic mclk,
    output logic [15:0] data_in,
    output logic fifo_write_clock,
    output logic pixel_clk,
    output logic parallel_load,
    output logic serial_in,
    input wire logic serial_out_last,
    input wire logic serial_out_tap8
);
    logic got_last;
    logic got_tap;

    initial
    begin
        data_in = 16'h0000;
        fifo_write_clock = 1'b0;
        pixel_clk = 1'b0;
        parallel_load = 1'b0;
        serial_in = 1'b0;
        got_last = 1'b0;
        got_tap = 1'b0;
    end

    // Clock phases of four mclk stay above the three-cycle sampling minimum
    task automatic put_word(input logic [15:0] w);
        @(posedge mclk);
        data_in <= w;
        repeat (3) @(posedge mclk);
        fifo_write_clock <= 1'b1;
        repeat (4) @(posedge mclk);
        fifo_write_clock <= 1'b0;
        repeat (3) @(posedge mclk);
        // Hold time over: show the inverse so a late capture cannot pass
        data_in <= ~w;
    endtask : put_word

    // One 400 ns pixel clock; the clock stands low between calls
    task automatic pix(input logic pl, input logic si);
        @(posedge mclk);
        parallel_load <= pl;
        serial_in <= si;
        repeat (2) @(posedge mclk);
        pixel_clk <= 1'b1;
        repeat (4) @(posedge mclk);
        pixel_clk <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        got_last = serial_out_last;
        got_tap = serial_out_tap8;
    endtask : pix
endmodule : vps_far_model

// File: sim/video_parallel_to_serial_shifter_bench.sv
// Bench for the video shifter: bus tasks, a far-side model, expected model.
// Assumes vps_pkg and the design are compiled first.
`timescale 1ns/1ps
module video_parallel_to_serial_shifter_bench;
    logic mclk;
    logic srst;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] data_in;
    logic fifo_write_clock;
    logic pixel_clk;
    logic parallel_load;
    logic serial_in;
    logic serial_out_last;
    logic serial_out_tap8;
    int n_mismatch;
    int compares;
    int cyc;
    logic [6:0] ctl;
    logic [15:0] q[$];
    logic [15:0] hold;
    logic [15:0] sr;
    logic el;
    logic et;
    logic [31:0] rd;

    vps_shifter u_dut (.mclk(mclk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .data_in(data_in),
        .fifo_write_clock(fifo_write_clock), .pixel_clk(pixel_clk),
        .parallel_load(parallel_load), .serial_in(serial_in),
        .serial_out_last(serial_out_last), .serial_out_tap8(serial_out_tap8));

    vps_far_model u_far (.mclk(mclk), .data_in(data_in), .fifo_write_clock(fifo_write_clock),
        .pixel_clk(pixel_clk), .parallel_load(parallel_load), .serial_in(serial_in),
        .serial_out_last(serial_out_last), .serial_out_tap8(serial_out_tap8));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    // The slave sets the pace: hold the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       input logic [3:0] be);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        // Only the bench-wide cycle ceiling ends a wait that never answers
        do
        begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'hf);
        check(rd, exp);
    endtask : rdchk

    task automatic set_ctl(input logic [6:0] v);
        ctl = v;
        bus(1'b1, vps_pkg::ADDR_CTRL, {25'h0000000, v}, 4'hf);
    endtask : set_ctl

    function automatic logic [31:0] stat_exp();
        return {24'h000000, et, el, q.size() == 0, q.size() == 4, 1'b0, 3'(q.size())};
    endfunction : stat_exp

    function automatic logic bypass();
        return ctl[1:0] == vps_pkg::CFG_LATCH || ctl[1:0] == vps_pkg::CFG_FLOP;
    endfunction : bypass

    task automatic push(input logic [15:0] w);
        u_far.put_word(w);
        if (bypass())
            hold = w;
        else if (q.size() < 4)
            q.push_back(w);
    endtask : push

    task automatic pix(input logic pl, input logic si);
        logic [15:0] w;
        u_far.pix(pl, si);
        if (pl && !ctl[vps_pkg::CF_LDINH] && (bypass() || q.size() > 0))
        begin
            w = bypass() ? hold : q.pop_front();
            if (ctl[vps_pkg::CF_RECIRC] && !bypass())
                q.push_back(w);
            sr = w;
        end
        else if (!ctl[vps_pkg::CF_INHIBIT])
            sr = {sr[14:0], si};
        el = ctl[vps_pkg::CF_FREEZE] ? ctl[vps_pkg::CF_LEVEL] : sr[15];
        et = ctl[vps_pkg::CF_FREEZE] ? et : sr[7];
        check({31'h0, u_far.got_last}, {31'h0, el});
        check({31'h0, u_far.got_tap}, {31'h0, et});
        rdchk(vps_pkg::ADDR_SHIFT, {16'h0000, sr});
    endtask : pix

    initial
    begin
        srst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        n_mismatch = 0;
        compares = 0;
        cyc = 0;
        ctl = 7'h00;
        hold = 16'h0000;
        sr = 16'h0000;
        el = 1'b0;
        et = 1'b0;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        rdchk(vps_pkg::ADDR_CTRL, 32'h0000_0000);
        rdchk(vps_pkg::ADDR_STATUS, 32'h0000_0020);
        rdchk(4'h2, 32'h0000_0000);
        bus(1'b1, vps_pkg::ADDR_STATUS, 32'hffff_ffff, 4'hf);
        bus(1'b1, vps_pkg::ADDR_CTRL, 32'h0000_007f, 4'he);
        rdchk(vps_pkg::ADDR_CTRL, 32'h0000_0000);
        // Three writes queue up, nothing reaches the register yet
        push(16'ha5c3);
        push(16'h3c5a);
        push(16'hf00f);
        rdchk(vps_pkg::ADDR_STATUS, stat_exp());
        rdchk(vps_pkg::ADDR_SHIFT, 32'h0000_0000);
        pix(1'b1, 1'b0);
        for (int i = 0; i < 16; i++)
            pix(1'b0, i[0]);
        pix(1'b1, 1'b1);
        // Overfill: the fourth extra word is dropped
        push(16'h1234);
        push(16'h8001);
        push(16'h7e7e);
        push(16'h4bb4);
        rdchk(vps_pkg::ADDR_STATUS, stat_exp());
        repeat (4) pix(1'b1, 1'b0);
        pix(1'b1, 1'b1);
        rdchk(vps_pkg::ADDR_STATUS, stat_exp());
        push(16'h9669);
        set_ctl(7'h10);
        pix(1'b0, 1'b1);
        pix(1'b1, 1'b0);
        set_ctl(7'h00);
        push(16'h0ff0);
        set_ctl(7'h20);
        pix(1'b1, 1'b1);
        set_ctl(7'h00);
        rdchk(vps_pkg::ADDR_STATUS, stat_exp());
        pix(1'b1, 1'b0);
        // Scroll by three bits at each frozen level
        for (int lv = 0; lv < 2; lv++)
        begin
            set_ctl({3'h0, lv[0], 3'h4});
            repeat (3) pix(1'b0, lv[0]);
            set_ctl(7'h00);
            pix(1'b0, 1'b0);
        end
        set_ctl(7'h40);
        push(16'hc001);
        repeat (3) pix(1'b1, 1'b0);
        rdchk(vps_pkg::ADDR_STATUS, stat_exp());
        set_ctl(7'h00);
        pix(1'b1, 1'b0);
        // Code 3 is the spare select and must behave as queue mode
        for (int m = 1; m < 4; m++)
        begin
            set_ctl({5'h00, m[1:0]});
            push({4'h5, m[3:0], 8'h3c});
            rdchk(vps_pkg::ADDR_HOLD, {16'h0000, hold});
            pix(1'b1, 1'b0);
            pix(1'b1, 1'b1);
            rdchk(vps_pkg::ADDR_STATUS, stat_exp());
        end
        test_done();
    end
endmodule : video_parallel_to_serial_shifter_bench
